// file: verilog/timer_capture_compare_one_pulse.sv
// What this block does
// - active trigger edge sets latch flag and copies counter into latch
// - latch flag requests interrupt when enabled and cpu mask clear
// - latch flag cleared by status read then low byte access
// - high byte read blocks capture and flag until low byte read
// - newest capture overwrites the older latched count
// - trigger pins always watched, toggles by software also capture
// - edge select 2 in control two, edge 1 in control one
// - in single shot or pwm mode only channel 2 captures
// - compare values software read/write, reset to 8000h
// - match sets match flag, drives pin to level bit
// - match requests interrupt when enabled and cpu mask clear
// - match flag cleared by status read then low byte access
// - compare high write suspends channel until low write
// - pin enable hands pin to channel, else no level drive
// - div2 matches at equal, slower clocks at value plus one
// - force bit copies level to pin, no flag, no interrupt
// - force bits ignored in single shot or pwm mode
// - single shot bit in control two uses channel one
// - trigger reloads counter, drives level 2, flag, loads fffdh
// - single shot trigger flag raises interrupt if enabled
// - single shot counter match ends pulse with level 1
// - single shot never sets match flag 1, channel 2 match sets flag 2 but does not drive pin 2
// - pwm and single shot both set means only pwm
// - clock select: div 2, 4, 8, external
`timescale 1ns/1ps
`default_nettype none
`include "tcap_cfg.svh"
module timer_capture_compare_one_pulse (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // timer core link
  input wire tcap_pkg::word_t COUNT,
  input wire logic TIMER_TICK,
  input wire logic CPU_IRQ_MASK,
  output logic COUNT_RELOAD,
  output tcap_pkg::clk_sel_t CLOCK_SELECT,
  output logic PWM_ENABLE,
  output logic TIMER_IRQ,
  // pins
  input wire logic TRIGGER_INPUT_PIN1,
  input wire logic TRIGGER_INPUT_PIN2,
  output logic MATCH_OUTPUT_PIN1,
  output logic MATCH_OUTPUT_PIN2,
  output logic MATCH_PIN1_OE,
  output logic MATCH_PIN2_OE
);
  import tcap_pkg::*;

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  byte_t ctrl_one_reg;
  byte_t ctrl_two_reg;
  word_t latched_count1_reg;
  word_t latched_count2_reg;
  word_t compare_value1_reg;
  word_t compare_value2_reg;
  logic [1:0] latch_flag_reg;
  logic [1:0] match_flag_reg;
  logic [1:0] latch_armed_reg;
  logic [1:0] match_armed_reg;
  logic [1:0] latch_block_reg;
  logic [1:0] cmp_hold_reg;
  logic [1:0] pin_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] hit;
  logic [1:0] cap;
  logic [1:0] match;
  logic [1:0] level;
  logic [1:0] force_bit;
  logic acc;
  logic wr;
  logic rd;
  logic rd_status;
  logic trigger;
  mode_t mode;

  function automatic logic hit_at(input logic [5:0] a, input logic [5:0] o);
    hit_at = (a == o);
  endfunction

  // a single wait state gives registered read data; access happens on ack
  assign acc = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign wr = AVS_WRITE & ack_reg;
  assign rd = AVS_READ & ack_reg;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign AVS_READDATA = rdata_reg;
  assign rd_status = rd & hit_at(AVS_ADDRESS, `OFS_STATUS);

  always_comb begin
    if (ctrl_two_reg[`C2_PWM])
      mode = MODE_PWM;
    else if (ctrl_two_reg[`C2_SINGLE])
      mode = MODE_SINGLE;
    else
      mode = MODE_NORMAL;
  end

  assign CLOCK_SELECT = clk_sel_t'(ctrl_two_reg[`C2_CLKSEL_HI:`C2_CLKSEL_LO]);
  assign PWM_ENABLE = (mode == MODE_PWM);
  assign level = {ctrl_one_reg[`C1_LVL2], ctrl_one_reg[`C1_LVL1]};
  assign force_bit = {ctrl_one_reg[`C1_FORCE2], ctrl_one_reg[`C1_FORCE1]};

  always_ff @(posedge MCLK) begin
    if (!RST_N)
      ack_reg <= 1'b0;
    else
      ack_reg <= acc;
  end

  // compare values and control, software owned
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_one_reg <= 8'h00;
      ctrl_two_reg <= 8'h00;
      compare_value1_reg <= `CMP_RESET;
      compare_value2_reg <= `CMP_RESET;
    end else if (wr) begin
      unique case (AVS_ADDRESS)
        `OFS_CTRL_ONE: ctrl_one_reg <= AVS_WRITEDATA[7:0];
        `OFS_CTRL_TWO: ctrl_two_reg <= AVS_WRITEDATA[7:0];
        `OFS_CMP1_HI: compare_value1_reg[15:8] <= AVS_WRITEDATA[7:0];
        `OFS_CMP1_LO: compare_value1_reg[7:0] <= AVS_WRITEDATA[7:0];
        `OFS_CMP2_HI: compare_value2_reg[15:8] <= AVS_WRITEDATA[7:0];
        `OFS_CMP2_LO: compare_value2_reg[7:0] <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // capture
  // ----------------------------------------
  // pins always feed edge detectors
  edge_catch u_edge1 (
    .clk(MCLK),
    .rst_n(RST_N),
    .pin(TRIGGER_INPUT_PIN1),
    .rising(ctrl_one_reg[`C1_EDGE1]),
    .hit(hit[0])
  );
  edge_catch u_edge2 (
    .clk(MCLK),
    .rst_n(RST_N),
    .pin(TRIGGER_INPUT_PIN2),
    .rising(ctrl_two_reg[`C2_EDGE2]),
    .hit(hit[1])
  );

  // channel one edge is the single shot trigger
  assign trigger = hit[0] & (mode == MODE_SINGLE);
  assign COUNT_RELOAD = trigger;
  // channel 1 captures only in normal mode
  assign cap[0] = hit[0] & (mode == MODE_NORMAL) & ~latch_block_reg[0];
  assign cap[1] = hit[1] & ~latch_block_reg[1];

  // high byte read blocks until low byte read
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      latch_block_reg <= 2'b00;
    end else if (rd) begin
      if (hit_at(AVS_ADDRESS, `OFS_LATCH1_HI))
        latch_block_reg[0] <= 1'b1;
      if (hit_at(AVS_ADDRESS, `OFS_LATCH1_LO))
        latch_block_reg[0] <= 1'b0;
      if (hit_at(AVS_ADDRESS, `OFS_LATCH2_HI))
        latch_block_reg[1] <= 1'b1;
      if (hit_at(AVS_ADDRESS, `OFS_LATCH2_LO))
        latch_block_reg[1] <= 1'b0;
    end
  end

  // newest capture overwrites; trigger loads fffdh
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      latched_count1_reg <= 16'h0000;
      latched_count2_reg <= 16'h0000;
    end else begin
      if (trigger)
        latched_count1_reg <= `OPM_LATCH;
      else if (cap[0])
        latched_count1_reg <= COUNT;
      if (cap[1])
        latched_count2_reg <= COUNT;
    end
  end

  // ----------------------------------------
  // flags: set wins over clear
  // ----------------------------------------
  // latch flags, arm on status read, clear on low access
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      latch_flag_reg <= 2'b00;
      latch_armed_reg <= 2'b00;
    end else begin
      if (rd_status)
        latch_armed_reg <= latch_flag_reg;
      if (wr | rd) begin
        if (hit_at(AVS_ADDRESS, `OFS_LATCH1_LO) && latch_armed_reg[0]) begin
          latch_flag_reg[0] <= 1'b0;
          latch_armed_reg[0] <= 1'b0;
        end
        if (hit_at(AVS_ADDRESS, `OFS_LATCH2_LO) && latch_armed_reg[1]) begin
          latch_flag_reg[1] <= 1'b0;
          latch_armed_reg[1] <= 1'b0;
        end
      end
      if (cap[0] | trigger)
        latch_flag_reg[0] <= 1'b1;
      if (cap[1])
        latch_flag_reg[1] <= 1'b1;
    end
  end

  // ----------------------------------------
  // compare
  // ----------------------------------------
  // high write suspends channel until low write
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmp_hold_reg <= 2'b00;
    end else if (wr) begin
      if (hit_at(AVS_ADDRESS, `OFS_CMP1_HI))
        cmp_hold_reg[0] <= 1'b1;
      if (hit_at(AVS_ADDRESS, `OFS_CMP1_LO))
        cmp_hold_reg[0] <= 1'b0;
      if (hit_at(AVS_ADDRESS, `OFS_CMP2_HI))
        cmp_hold_reg[1] <= 1'b1;
      if (hit_at(AVS_ADDRESS, `OFS_CMP2_LO))
        cmp_hold_reg[1] <= 1'b0;
    end
  end

  // target shifts by one for slower timer clocks
  function automatic logic is_match(input word_t cnt, input word_t val,
                                    input clk_sel_t sel);
    word_t target;
    target = (sel == CLK_DIV2) ? val : 16'(val + 16'h0001);
    is_match = (cnt == target);
  endfunction

  // compared once per timer tick so a match is one event
  assign match[0] = TIMER_TICK & ~cmp_hold_reg[0] & (mode != MODE_PWM) &
    is_match(COUNT, compare_value1_reg, CLOCK_SELECT);
  assign match[1] = TIMER_TICK & ~cmp_hold_reg[1] & (mode != MODE_PWM) &
    is_match(COUNT, compare_value2_reg, CLOCK_SELECT);

  // match flags; flag 1 not set in single shot
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      match_flag_reg <= 2'b00;
      match_armed_reg <= 2'b00;
    end else begin
      if (rd_status)
        match_armed_reg <= match_flag_reg;
      if (wr | rd) begin
        if (hit_at(AVS_ADDRESS, `OFS_CMP1_LO) && match_armed_reg[0]) begin
          match_flag_reg[0] <= 1'b0;
          match_armed_reg[0] <= 1'b0;
        end
        if (hit_at(AVS_ADDRESS, `OFS_CMP2_LO) && match_armed_reg[1]) begin
          match_flag_reg[1] <= 1'b0;
          match_armed_reg[1] <= 1'b0;
        end
      end
      if (match[0] && mode == MODE_NORMAL)
        match_flag_reg[0] <= 1'b1;
      if (match[1])
        match_flag_reg[1] <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_reg <= 2'b00;
    end else if (mode == MODE_SINGLE) begin
      if (trigger)
        pin_reg[0] <= level[1];
      else if (match[0])
        pin_reg[0] <= level[0];
    end else if (mode == MODE_NORMAL) begin
      for (int i = 0; i < 2; i++) begin
        if (force_bit[i] || match[i])
          pin_reg[i] <= level[i];
      end
    end
  end

  // pin enables hand pins to the channels
  assign MATCH_OUTPUT_PIN1 = pin_reg[0];
  assign MATCH_OUTPUT_PIN2 = pin_reg[1];
  assign MATCH_PIN1_OE = ctrl_two_reg[`C2_PIN1_EN];
  assign MATCH_PIN2_OE = ctrl_two_reg[`C2_PIN2_EN];

  assign TIMER_IRQ = ~CPU_IRQ_MASK &
    ((ctrl_one_reg[`C1_LATCH_IE] & |latch_flag_reg) |
     (ctrl_one_reg[`C1_MATCH_IE] & |match_flag_reg));

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (acc && AVS_READ) begin
      rdata_reg <= 32'h0000_0000;
      unique case (AVS_ADDRESS)
        `OFS_CTRL_ONE: rdata_reg[7:0] <= ctrl_one_reg;
        `OFS_CTRL_TWO: rdata_reg[7:0] <= ctrl_two_reg;
        `OFS_STATUS: begin
          rdata_reg[`SR_LATCH1] <= latch_flag_reg[0];
          rdata_reg[`SR_MATCH1] <= match_flag_reg[0];
          rdata_reg[`SR_LATCH2] <= latch_flag_reg[1];
          rdata_reg[`SR_MATCH2] <= match_flag_reg[1];
        end
        `OFS_LATCH1_HI: rdata_reg[7:0] <= latched_count1_reg[15:8];
        `OFS_LATCH1_LO: rdata_reg[7:0] <= latched_count1_reg[7:0];
        `OFS_CMP1_HI: rdata_reg[7:0] <= compare_value1_reg[15:8];
        `OFS_CMP1_LO: rdata_reg[7:0] <= compare_value1_reg[7:0];
        `OFS_LATCH2_HI: rdata_reg[7:0] <= latched_count2_reg[15:8];
        `OFS_LATCH2_LO: rdata_reg[7:0] <= latched_count2_reg[7:0];
        `OFS_CMP2_HI: rdata_reg[7:0] <= compare_value2_reg[15:8];
        `OFS_CMP2_LO: rdata_reg[7:0] <= compare_value2_reg[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cap1;
    @(posedge MCLK) disable iff (!RST_N)
    cap[0] && !trigger |=> latch_flag_reg[0] && latched_count1_reg == $past(COUNT);
  endproperty
  a_cap1: assert property (p_cap1) else $error("capture 1 lost");

  property p_block;
    @(posedge MCLK) disable iff (!RST_N)
    latch_block_reg[1] && !latch_flag_reg[1] && !rd |=> !latch_flag_reg[1];
  endproperty
  a_block: assert property (p_block) else $error("blocked flag set");

  property p_cmp_rst;
    @(posedge MCLK) $fell(RST_N) |=> compare_value1_reg == 16'h8000;
  endproperty
  a_cmp_rst: assert property (p_cmp_rst) else $error("bad reset value");

  property p_match;
    @(posedge MCLK) disable iff (!RST_N)
    match[1] |=> match_flag_reg[1] &&
      ($past(mode) != MODE_NORMAL || pin_reg[1] == $past(level[1]));
  endproperty
  a_match: assert property (p_match) else $error("match missed");

  property p_irq;
    @(posedge MCLK) disable iff (!RST_N)
    CPU_IRQ_MASK |-> !TIMER_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");

  property p_hold;
    @(posedge MCLK) disable iff (!RST_N)
    cmp_hold_reg[0] |-> !match[0];
  endproperty
  a_hold: assert property (p_hold) else $error("match while held");

  property p_trig;
    @(posedge MCLK) disable iff (!RST_N)
    trigger |=> latch_flag_reg[0] && latched_count1_reg == 16'hfffd &&
      pin_reg[0] == $past(level[1]);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger wrong");

  property p_opm_flag;
    @(posedge MCLK) disable iff (!RST_N)
    mode == MODE_SINGLE && !match_flag_reg[0] |=> !match_flag_reg[0];
  endproperty
  a_opm_flag: assert property (p_opm_flag) else $error("flag 1 set");

  c_cap2: cover property (@(posedge MCLK) cap[1]);
  c_trig: cover property (@(posedge MCLK) trigger ##[1:200] match[0]);
  c_clear: cover property (@(posedge MCLK) $fell(latch_flag_reg[0]));
endmodule
`default_nettype wire

// file: include/tcap_cfg.svh
`ifndef TCAP_CFG_SVH
`define TCAP_CFG_SVH
// register offsets (byte addresses, one aligned word each)
`define OFS_CTRL_ONE 6'h00
`define OFS_CTRL_TWO 6'h04
`define OFS_STATUS 6'h08
`define OFS_LATCH1_HI 6'h0c
`define OFS_LATCH1_LO 6'h10
`define OFS_CMP1_HI 6'h14
`define OFS_CMP1_LO 6'h18
`define OFS_LATCH2_HI 6'h1c
`define OFS_LATCH2_LO 6'h20
`define OFS_CMP2_HI 6'h24
`define OFS_CMP2_LO 6'h28
// control one fields
`define C1_LATCH_IE 7
`define C1_MATCH_IE 6
`define C1_FORCE2 4
`define C1_FORCE1 3
`define C1_EDGE1 1
`define C1_LVL1 0
`define C1_LVL2 2
// control two fields
`define C2_PIN1_EN 7
`define C2_PIN2_EN 6
`define C2_SINGLE 5
`define C2_PWM 4
`define C2_CLKSEL_HI 3
`define C2_CLKSEL_LO 2
`define C2_EDGE2 1
// status fields
`define SR_LATCH1 7
`define SR_MATCH1 6
`define SR_LATCH2 4
`define SR_MATCH2 3
// reset, reload and trigger load values
`define CMP_RESET 16'h8000
`define CNT_RELOAD 16'hfffc
`define OPM_LATCH 16'hfffd
`endif

// file: include/tcap_pkg.sv
package tcap_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT} clk_sel_t;
  typedef enum {MODE_NORMAL, MODE_SINGLE, MODE_PWM} mode_t;
endpackage

// file: verilog/edge_catch.sv
`timescale 1ns/1ps
`default_nettype none
module edge_catch (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and edge selection (1 = rising)
  input wire logic pin,
  input wire logic rising,
  // one pulse per qualifying transition
  output logic hit
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two-stage sync
  // chain runs through reset so a pin that idles high is settled when
  // reset lifts and gives no false edge
  always_ff @(posedge clk) begin
    sync1_reg <= pin;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end

  assign hit = rst_n &
    (rising ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg));
endmodule
`default_nettype wire

// file: verif/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// trigger sources and waveform loads
// -------------------------------------------------------------
module pin_world (
  // clock
  input wire logic clk,
  // commanded source levels
  input wire logic lvl1,
  input wire logic lvl2,
  output logic trig1,
  output logic trig2,
  // compare pins and what the loads see
  input wire logic out1,
  input wire logic oe1,
  output logic load1
);
  logic last1;
  // sources change on the clock and hold for many cycles
  always_ff @(posedge clk) begin
    trig1 <= lvl1;
    trig2 <= lvl2;
  end
  // no pull on the line: an undriven pin shows the opposite level
  always_ff @(posedge clk) begin
    if (oe1) last1 <= out1;
  end
  assign load1 = oe1 ? out1 : ~last1;
endmodule
`default_nettype wire

// file: verif/tb_timer_capture_compare_one_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcap_cfg.svh"
module tb_timer_capture_compare_one_pulse;
  import tcap_pkg::*;
  logic mclk, rst_n, avs_read, avs_write, tick, mask, lvl1, lvl2;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, reload, pwm_en, irq, trig1, trig2, load1;
  logic pin1, pin2, oe1, oe2, seen;
  word_t count;
  clk_sel_t clk_sel;
  int miscompares = 0;
  int n_compared = 0;
  byte_t q;

  timer_capture_compare_one_pulse dut (
    .MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .COUNT(count), .TIMER_TICK(tick),
    .CPU_IRQ_MASK(mask), .COUNT_RELOAD(reload), .CLOCK_SELECT(clk_sel),
    .PWM_ENABLE(pwm_en), .TIMER_IRQ(irq), .TRIGGER_INPUT_PIN1(trig1),
    .TRIGGER_INPUT_PIN2(trig2), .MATCH_OUTPUT_PIN1(pin1),
    .MATCH_OUTPUT_PIN2(pin2), .MATCH_PIN1_OE(oe1), .MATCH_PIN2_OE(oe2));

  pin_world world (.clk(mclk), .lvl1(lvl1), .lvl2(lvl2), .trig1(trig1),
    .trig2(trig2), .out1(pin1), .oe1(oe1), .load1(load1));

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic [5:0] a, input logic w, input byte_t d,
                     output byte_t r);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input byte_t d);
    byte_t r;
    acc(a, 1'b1, d, r);
  endtask

  task automatic rc(input logic [5:0] a, input byte_t e, input string n);
    byte_t r;
    acc(a, 1'b0, 8'h00, r);
    chk(n, e, r);
  endtask

  task automatic tr(input int ch, input logic v, input word_t c);
    count <= c;
    if (ch == 1) lvl1 <= v;
    else lvl2 <= v;
    repeat (6) @(posedge mclk);
  endtask

  task automatic tk(input word_t c);
    count <= c;
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // -------------------------------------------------------------
  // clock, watchdog, tests
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #500us;
    miscompares++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    tick = 1'b0;
    mask = 1'b0;
    lvl1 = 1'b0;
    lvl2 = 1'b0;
    count = 16'h0000;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chk("pin1_reset", 1'b0, pin1);
    rc(`OFS_CMP1_HI, 8'h80, "cmp1_hi");
    rc(`OFS_CMP2_HI, 8'h80, "cmp2_hi");
    rc(`OFS_CMP2_LO, 8'h00, "cmp2_lo");
    rc(`OFS_STATUS, 8'h00, "status");
    wr(6'h30, 8'hff);
    rc(6'h30, 8'h00, "unmapped");
    // capture channel 1 on rising, channel 2 on falling
    wr(`OFS_CTRL_ONE, 8'h82);
    tr(1, 1'b1, 16'h1234);
    chk("irq", 1'b1, irq);
    mask <= 1'b1;
    @(posedge mclk);
    chk("irq_masked", 1'b0, irq);
    mask <= 1'b0;
    rc(`OFS_STATUS, 8'h80, "status");
    rc(`OFS_LATCH1_HI, 8'h12, "latch1_hi");
    rc(`OFS_LATCH1_LO, 8'h34, "latch1_lo");
    rc(`OFS_STATUS, 8'h00, "status");
    rc(`OFS_LATCH1_HI, 8'h12, "latch1_hi");
    tr(1, 1'b0, 16'h5678);
    tr(1, 1'b1, 16'h5678);
    rc(`OFS_STATUS, 8'h00, "status_blocked");
    rc(`OFS_LATCH1_LO, 8'h34, "latch1_lo");
    tr(1, 1'b0, 16'h1111);
    tr(1, 1'b1, 16'h1111);
    tr(1, 1'b0, 16'h2222);
    tr(1, 1'b1, 16'h2222);
    rc(`OFS_LATCH1_HI, 8'h22, "latch1_hi");
    rc(`OFS_STATUS, 8'h80, "status");
    rc(`OFS_LATCH1_LO, 8'h22, "latch1_lo");
    tr(2, 1'b1, 16'haaaa);
    rc(`OFS_STATUS, 8'h00, "status_ch2_rise");
    tr(2, 1'b0, 16'hbbbb);
    rc(`OFS_STATUS, 8'h10, "status_ch2");
    rc(`OFS_LATCH2_HI, 8'hbb, "latch2_hi");
    wr(`OFS_LATCH2_LO, 8'h00);
    rc(`OFS_STATUS, 8'h00, "status");
    rc(`OFS_LATCH2_LO, 8'hbb, "latch2_lo");
    // compare channel 1, timer clock divided by 2 then by 4
    wr(`OFS_CTRL_TWO, 8'h80);
    wr(`OFS_CTRL_ONE, 8'h41);
    wr(`OFS_CMP1_HI, 8'h01);
    wr(`OFS_CMP1_LO, 8'h00);
    rc(`OFS_CMP1_HI, 8'h01, "cmp1_hi");
    tk(16'h0100);
    chk("pin1", 1'b1, pin1);
    chk("load1", 1'b1, load1);
    chk("irq_match", 1'b1, irq);
    rc(`OFS_STATUS, 8'h40, "status");
    rc(`OFS_CMP1_LO, 8'h00, "cmp1_lo");
    rc(`OFS_STATUS, 8'h00, "status");
    wr(`OFS_CMP1_HI, 8'h02);
    tk(16'h0200);
    rc(`OFS_STATUS, 8'h00, "status_suspended");
    wr(`OFS_CMP1_LO, 8'h00);
    wr(`OFS_CTRL_TWO, 8'h84);
    @(posedge mclk);
    chk("clock_select", CLK_DIV4, clk_sel);
    tk(16'h0200);
    rc(`OFS_STATUS, 8'h00, "status_div4_equal");
    tk(16'h0201);
    rc(`OFS_STATUS, 8'h40, "status_div4_plus1");
    rc(`OFS_CMP1_LO, 8'h00, "cmp1_lo");
    // compare channel 2 at value plus one
    wr(`OFS_CMP2_HI, 8'h04);
    wr(`OFS_CMP2_LO, 8'h00);
    tk(16'h0401);
    chk("irq_match2", 1'b1, irq);
    rc(`OFS_STATUS, 8'h08, "status_match2");
    rc(`OFS_CMP2_LO, 8'h00, "cmp2_lo");
    // forced level on pin 2
    wr(`OFS_CTRL_ONE, 8'h14);
    chk("oe2_off", 1'b0, oe2);
    wr(`OFS_CTRL_TWO, 8'h40);
    @(posedge mclk);
    chk("oe2", 1'b1, oe2);
    chk("pin2_forced", 1'b1, pin2);
    rc(`OFS_STATUS, 8'h00, "status_forced");
    // single shot: trigger, pulse, end
    wr(`OFS_CTRL_TWO, 8'ha0);
    wr(`OFS_CTRL_ONE, 8'h8e);
    tr(1, 1'b0, 16'h0050);
    lvl1 <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      if (reload === 1'b1) seen = 1'b1;
    end
    chk("count_reload", 1'b1, seen);
    chk("pin1_pulse", 1'b1, pin1);
    chk("irq_single", 1'b1, irq);
    rc(`OFS_STATUS, 8'h80, "status");
    rc(`OFS_LATCH1_HI, 8'hff, "latch1_hi");
    rc(`OFS_LATCH1_LO, 8'hfd, "latch1_lo");
    tk(16'h0200);
    chk("pin1_end", 1'b0, pin1);
    rc(`OFS_STATUS, 8'h00, "status_no_match1");
    tk(16'h0300);
    chk("pin1_hold", 1'b0, pin1);
    tr(2, 1'b1, 16'hcccc);
    tr(2, 1'b0, 16'hcccc);
    rc(`OFS_STATUS, 8'h10, "status_ch2_single");
    wr(`OFS_CTRL_TWO, 8'h30);
    @(posedge mclk);
    chk("pwm_enable", 1'b1, pwm_en);
    complete_run();
  end
endmodule
`default_nettype wire
